// *** rtl/mbs_defs.svh ***
// constants for the memory bank select block
`ifndef MBS_DEFS_SVH
`define MBS_DEFS_SVH

`define MBS_BANK_PORT_ADDR 8'hff
`define MBS_BANK_RESET 8'h01
`define MBS_UPPER_RESET 8'h00
`define MBS_UPPER_LSB 16
`define MBS_UPPER_W 8
`define MBS_JUMPER_W 3
`define MBS_STRAP_IN 2'h0
`define MBS_STRAP_PORT 2'h1
`define MBS_STRAP_EXT 2'h2
`define MBS_STRAP_LINE 2'h3

`endif

// *** rtl/mbs_pkg.sv ***
// types for the memory bank select block
package mbs_pkg;

    typedef enum logic [1:0] {
        MBS_MODE_LINE = 2'b00,
        MBS_MODE_PORT = 2'b01,
        MBS_MODE_EXT = 2'b10
    } mbs_mode_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic memrq_n;
        logic iorq_n;
        logic wr_n;
        logic rd_n;
        logic memex;
    } mbs_bus_s;

    typedef struct packed {
        logic [7:0] base_hi;
        logic [7:0] mask_hi;
        logic [7:0] upper_match;
        logic [7:0] upper_mask;
    } mbs_decode_s;

endpackage

// *** rtl/mbs_capture.sv ***
// holding register loaded on a qualified strobe edge
module mbs_capture #(
    parameter int W = 8,
    parameter logic [7:0] RST = 8'h00
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // load
    input wire logic load_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_q;

    always_comb begin
        nxt_q = q_ff;
        if (load_i) begin
            nxt_q = d_i;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q_ff <= RST[W-1:0];
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign q_o = q_ff;
endmodule

// *** rtl/mbs_top.sv ***
// memory card bank selection and upper address demultiplexing
// ------------------------------------------------------------
// Notes on behaviour
// - the card select always includes the memory extension line as a decode term.
// - with the extension line low the primary 64K space is what gets enabled.
// - a strap picks whether the card answers to a high or low extension line level.
// - the extension line splits memory into two 64K banks for 128K total.
// - a port-driven scheme can enable individual 64K banks, still qualified by the line.
// - an I/O write to address ff latches the bank-select value from the data bus.
// - jumpers choose which latch output enables this card.
// - system reset forces the latch to select bank 1.
// - data bit n carries address bit n+16 during multiplexed addressing.
// - the card captures, holds and decodes the upper address bits.
// ------------------------------------------------------------
`include "mbs_defs.svh"

module mbs_top
    import mbs_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // backplane bus
    input wire mbs_bus_s bus_i,
    input wire logic ale_i,
    // straps and jumpers
    input wire mbs_mode_e mode_i,
    input wire logic memex_high_i,
    input wire logic [2:0] jumper_i,
    input wire logic mux_en_i,
    input wire mbs_decode_s decode_i,
    // user edge bank enables
    input wire logic [7:0] ext_bank_i,
    // outputs
    output logic mem_sel_o,
    output logic [7:0] bank_latch_o,
    output logic [7:0] upper_addr_o
);

    // ------------------------------------------------------------
    // bus cycle decode
    // ------------------------------------------------------------
    logic io_req;
    logic mem_req;
    logic wr_act;
    logic port_hit;
    logic port_wr;

    always_comb begin
        io_req = !bus_i.iorq_n;
        mem_req = !bus_i.memrq_n;
        wr_act = !bus_i.wr_n;
        // io ports decode only the low address byte
        port_hit = (bus_i.addr[7:0] == `MBS_BANK_PORT_ADDR);
        // io write cycle addressed to the bank port
        port_wr = io_req && wr_act && port_hit;
    end

    // ------------------------------------------------------------
    // port write strobe
    // ------------------------------------------------------------
    logic wr_seen_ff;
    logic nxt_wr_seen;
    logic port_strobe;

    always_comb begin
        nxt_wr_seen = port_wr;
        // a write held over several cycles loads only once
        port_strobe = port_wr && !wr_seen_ff;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_seen_ff <= 1'b0;
        end else begin
            wr_seen_ff <= nxt_wr_seen;
        end
    end

    // ------------------------------------------------------------
    // bank select latch
    // ------------------------------------------------------------
    logic [7:0] latch_q;

    // reset value selects bank 1 so single-bank software still runs
    mbs_capture #(
        .W(`MBS_UPPER_W),
        .RST(`MBS_BANK_RESET)
    ) u_bank_latch (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .load_i(port_strobe),
        .d_i(bus_i.data),
        .q_o(latch_q)
    );

    // ------------------------------------------------------------
    // upper address holding
    // ------------------------------------------------------------
    logic upper_load;
    logic [7:0] upper_q;

    always_comb begin
        // loads on every cycle the address strobe is up with the mux strap on, last one wins
        upper_load = ale_i && mux_en_i;
    end

    // d[n] is a[n+16] while the address strobe is up
    mbs_capture #(
        .W(`MBS_UPPER_W),
        .RST(`MBS_UPPER_RESET)
    ) u_upper (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .load_i(upper_load),
        .d_i(bus_i.data),
        .q_o(upper_q)
    );

    // ------------------------------------------------------------
    // strap decode
    // ------------------------------------------------------------
    logic mode_line;
    logic mode_port;
    logic mode_ext;

    always_comb begin
        mode_line = 1'b0;
        mode_port = 1'b0;
        mode_ext = 1'b0;
        case (mode_i)
            MBS_MODE_LINE: begin
                mode_line = 1'b1;
            end
            MBS_MODE_PORT: begin
                mode_port = 1'b1;
            end
            MBS_MODE_EXT: begin
                mode_ext = 1'b1;
            end
            default: begin
                // spare strap code leaves every enable off, card never selects
                mode_line = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // jumper decode
    // ------------------------------------------------------------
    logic [7:0] jumper_hot;

    always_comb begin
        jumper_hot = 8'h00;
        for (int i = 0; i < 8; i++) begin
            jumper_hot[i] = (jumper_i == 3'(i));
        end
    end

    // ------------------------------------------------------------
    // bank enable
    // ------------------------------------------------------------
    logic [7:0] port_en_vec;
    logic [7:0] ext_en_vec;
    logic bank_ok;

    always_comb begin
        // jumper picks the latch output for this card
        port_en_vec = latch_q & jumper_hot;
        // external port bit from the user edge
        ext_en_vec = ext_bank_i & jumper_hot;
        bank_ok = 1'b0;
        if (mode_line) begin
            bank_ok = 1'b1;
        end else if (mode_port) begin
            bank_ok = |port_en_vec;
        end else if (mode_ext) begin
            bank_ok = |ext_en_vec;
        end
    end

    // ------------------------------------------------------------
    // extension line qualification
    // ------------------------------------------------------------
    logic primary_hit;
    logic alt_hit;
    logic line_ok;

    always_comb begin
        // low line level is the primary 64K space
        primary_hit = !bus_i.memex && !memex_high_i;
        // high strap moves the card into the alternate bank
        alt_hit = bus_i.memex && memex_high_i;
        line_ok = primary_hit || alt_hit;
    end

    // ------------------------------------------------------------
    // low address compare
    // ------------------------------------------------------------
    logic [7:0] low_miss;
    logic low_ok;

    always_comb begin
        low_miss = (bus_i.addr[15:8] ^ decode_i.base_hi) & decode_i.mask_hi;
        low_ok = (low_miss == 8'h00);
    end

    // ------------------------------------------------------------
    // upper address compare
    // ------------------------------------------------------------
    logic [7:0] upper_miss;
    logic upper_ok;

    always_comb begin
        upper_miss = (upper_q ^ decode_i.upper_match) & decode_i.upper_mask;
        // strap off lets a card without mux wiring ignore the held byte
        upper_ok = !mux_en_i || (upper_miss == 8'h00);
    end

    // ------------------------------------------------------------
    // card select
    // ------------------------------------------------------------
    logic sel_ff;
    logic nxt_sel;

    always_comb begin
        // extension line is always a term, in every mode
        nxt_sel = mem_req && line_ok && bank_ok && low_ok && upper_ok;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sel_ff <= 1'b0;
        end else begin
            sel_ff <= nxt_sel;
        end
    end

    // ------------------------------------------------------------
    // bank latch mirror
    // ------------------------------------------------------------
    logic [7:0] bank_out_ff;
    logic [7:0] nxt_bank_out;

    always_comb begin
        // one extra stage keeps the output straight off a flip-flop
        nxt_bank_out = latch_q;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bank_out_ff <= `MBS_BANK_RESET;
        end else begin
            bank_out_ff <= nxt_bank_out;
        end
    end

    // ------------------------------------------------------------
    // upper address mirror
    // ------------------------------------------------------------
    logic [7:0] upper_out_ff;
    logic [7:0] nxt_upper_out;

    always_comb begin
        nxt_upper_out = upper_q;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            upper_out_ff <= `MBS_UPPER_RESET;
        end else begin
            upper_out_ff <= nxt_upper_out;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign mem_sel_o = sel_ff;
    assign bank_latch_o = bank_out_ff;
    assign upper_addr_o = upper_out_ff;
endmodule

// *** testbench/mbs_props.sv ***
// port assertions for mbs_top
module mbs_props
    import mbs_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire mbs_bus_s bus_i,
    input wire logic ale_i,
    input wire mbs_mode_e mode_i,
    input wire logic memex_high_i,
    input wire logic mux_en_i,
    input wire logic [2:0] jumper_i,
    input wire logic mem_sel_o,
    input wire logic [7:0] bank_latch_o,
    input wire logic [7:0] upper_addr_o
);
    timeunit 1ns / 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // first cycle of an io write to the bank port, after a cycle without one
    sequence s_wr;
        !(!bus_i.iorq_n && !bus_i.wr_n && bus_i.addr[7:0] == 8'hff) ##1
            (!bus_i.iorq_n && !bus_i.wr_n && bus_i.addr[7:0] == 8'hff);
    endsequence
    sequence s_ale; ale_i && mux_en_i; endsequence
    property p_mx; mem_sel_o |-> $past(bus_i.memex) == $past(memex_high_i); endproperty
    a_mx: assert property (p_mx) else $error("memex");
    property p_rq; mem_sel_o |-> !$past(bus_i.memrq_n); endproperty
    a_rq: assert property (p_rq) else $error("memrq");
    property p_m3; $past(mode_i) == 2'h3 |-> !mem_sel_o; endproperty
    a_m3: assert property (p_m3) else $error("mode");
    property p_pt; mem_sel_o && $past(mode_i) == MBS_MODE_PORT |-> bank_latch_o[$past(jumper_i)]; endproperty
    a_pt: assert property (p_pt) else $error("port");
    property p_rs; !$past(nrst_i) |-> bank_latch_o == 8'h01 && upper_addr_o == 8'h00; endproperty
    a_rs: assert property (p_rs) else $error("reset");
    property p_ld; s_wr |-> ##2 bank_latch_o == $past(bus_i.data, 2); endproperty
    a_ld: assert property (p_ld) else $error("load");
    property p_hd; $changed(bank_latch_o) |-> !$past(bus_i.wr_n, 2) && !$past(bus_i.iorq_n, 2); endproperty
    a_hd: assert property (p_hd) else $error("hold");
    property p_up; s_ale |-> ##2 upper_addr_o == $past(bus_i.data, 2); endproperty
    a_up: assert property (p_up) else $error("upper");
endmodule
bind mbs_top mbs_props u_props (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .bus_i(bus_i),
    .ale_i(ale_i),
    .mode_i(mode_i),
    .memex_high_i(memex_high_i),
    .mux_en_i(mux_en_i),
    .jumper_i(jumper_i),
    .mem_sel_o(mem_sel_o),
    .bank_latch_o(bank_latch_o),
    .upper_addr_o(upper_addr_o)
);

// *** testbench/mbs_cpu.sv ***
// processor card model mastering the bus
module mbs_cpu
    import mbs_pkg::*;
(
    input wire logic clk_i,
    output mbs_bus_s bus_o,
    output logic ale_o
);
    timeunit 1ns / 1ps;
    initial {bus_o, ale_o} = 30'h3ffffffe;
    // released data lines show the inverse so stale values never pass
    task automatic io_wr(input logic [7:0] d);
        @(negedge clk_i) bus_o = {16'h00ff, d, 5'h12};
        @(negedge clk_i) bus_o = {16'h0, ~d, 5'h1e};
    endtask
    // upper byte rides the data bus while ale is high
    task automatic mem_cyc(input logic [15:0] a, logic [7:0] u, logic mx);
        @(negedge clk_i) {bus_o.data, ale_o} = {u, 1'b1};
        @(negedge clk_i) {bus_o, ale_o} = {a, ~u, 4'h6, mx, 1'b0};
        @(negedge clk_i) bus_o = {~a, u, 4'hf, mx};
    endtask
endmodule

// *** testbench/tb_top.sv ***
// random bench for mbs_top
module tb_top
    import mbs_pkg::*;
;
    timeunit 1ns / 1ps;
    logic clk_i = 0, nrst_i = 0, ale_i, memex_high_i, mux_en_i, mem_sel_o;
    mbs_bus_s bus_i;
    mbs_mode_e mode_i;
    logic [2:0] jumper_i;
    mbs_decode_s decode_i;
    logic [7:0] ext_bank_i, bank_latch_o, upper_addr_o, lat, u, up;
    logic [15:0] a;
    int err_count = 0, tests_run = 0, cyc = 0;
    always #2 clk_i = ~clk_i;
    mbs_cpu cpu (.clk_i(clk_i), .bus_o(bus_i), .ale_o(ale_i));
    mbs_top DUT (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .bus_i(bus_i),
        .ale_i(ale_i),
        .mode_i(mode_i),
        .memex_high_i(memex_high_i),
        .jumper_i(jumper_i),
        .mux_en_i(mux_en_i),
        .decode_i(decode_i),
        .ext_bank_i(ext_bank_i),
        .mem_sel_o(mem_sel_o),
        .bank_latch_o(bank_latch_o),
        .upper_addr_o(upper_addr_o)
    );
    task automatic chk(input string n, input logic [7:0] s, e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    function automatic logic [7:0] sel(input logic mx);
        logic ok;
        ok = mode_i == 0 || mode_i == 1 && lat[jumper_i] || mode_i == 2 && ext_bank_i[jumper_i];
        return 8'(ok && mx == memex_high_i && ((a[15:8] ^ decode_i.base_hi) & decode_i.mask_hi) == 0 &&
            (!mux_en_i || ((u ^ decode_i.upper_match) & decode_i.upper_mask) == 0));
    endfunction
    always @(posedge clk_i) if (++cyc > 9000) begin
        err_count++;
        end_sim();
    end
    initial begin
        {memex_high_i, mux_en_i, jumper_i, decode_i, ext_bank_i} = '0;
        mode_i = MBS_MODE_LINE;
        lat = 8'h01;
        up = 8'h00;
        void'($urandom(32'h5153));
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        nrst_i = 1;
        for (int i = 0; i < 400; i++) begin
            // mid-run reset brings back bank 1 and clears the held upper byte
            if (i == 200) begin
                nrst_i = 0;
                repeat (2) @(negedge clk_i);
                chk("rst_latch", bank_latch_o, 8'h01);
                chk("rst_upper", upper_addr_o, 8'h00);
                nrst_i = 1;
                lat = 8'h01;
                up = 8'h00;
            end
            chk("latch", bank_latch_o, lat);
            mode_i = mbs_mode_e'(2'($urandom));
            {memex_high_i, mux_en_i, jumper_i, ext_bank_i, decode_i} = 45'({$urandom, $urandom});
            if (i % 4 == 0) begin
                lat = 8'($urandom);
                cpu.io_wr(lat);
            end
            // small offsets keep the decode near a match
            a = {decode_i.base_hi ^ 8'(i % 3), 8'($urandom)};
            u = decode_i.upper_match ^ 8'(i % 5);
            cpu.mem_cyc(a, u, i[1]);
            chk("sel", 8'(mem_sel_o), sel(i[1]));
            if (mux_en_i) begin
                up = u;
            end
            chk("upper", upper_addr_o, up);
        end
        end_sim();
    end
endmodule
